// File: hdl/fitpc_pkg.sv
// Package for the flag, interrupt, timer-expired and link-direction pin control block.
// Assumes a single 20 MHz system clock and a synchronous active-low reset.
package fitpc_pkg;

  localparam int unsigned CLK_FREQ_HZ       = 20_000_000;
  localparam int unsigned NUM_FLAGS         = 4;
  localparam int unsigned NUM_IRQS          = 4;
  localparam int unsigned NUM_LINKS         = 4;
  localparam int unsigned SYNC_STAGES       = 2;
  localparam int unsigned TMR_PULSE_CYCLES  = 4;
  localparam int unsigned STRAP_LINK_INDEX  = 2;

  // Reset values and timer pulse length
  localparam logic [3:0] FLAG_DIR_RST       = 4'h0;
  localparam logic [3:0] FLAG_OUT_RST       = 4'h0;
  localparam logic [3:0] IRQ_PEND_RST       = 4'h0;
  localparam logic [2:0] TMR_CNT_RST        = 3'h0;
  localparam logic [2:0] TMR_PULSE_LEN      = 3'h4;

  // Impedance select codes
  localparam logic [2:0] IMP_NONE_A         = 3'h0;
  localparam logic [2:0] IMP_NONE_B         = 3'h1;
  localparam logic [2:0] IMP_LINK_ONLY      = 3'h2;
  localparam logic [2:0] IMP_ADC_ONLY       = 3'h4;
  localparam logic [2:0] IMP_BOTH           = 3'h6;
  localparam logic [2:0] IMP_DEFAULT        = 3'h6;

  // Drive strength levels
  localparam logic [2:0] DS_DEFAULT         = 3'h7;
  localparam logic [2:0] DS_MAX             = 3'h7;

  typedef enum logic {
    FITPC_TRIG_LEVEL,
    FITPC_TRIG_EDGE
  } fitpc_trig_t;

endpackage : fitpc_pkg

// File: hdl/fitpc_sync.sv
// Two-flop synchroniser for one asynchronous level.
// Assumes the destination clock is CLOCK_I; the first flop feeds only the second.
`timescale 1ns/1ns
module fitpc_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Data
  input  wire logic async_i,
  input  wire logic rst_val_i,
  output logic      sync_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
    if (!rst_n_i) begin
      meta_d = rst_val_i;
      sync_d = rst_val_i;
    end
  end

  always_ff @(posedge clk_i) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_o = sync_q;

endmodule : fitpc_sync

// File: hdl/fitpc_top.sv
// Pin control for program flags, interrupt requests, timer-expired pulse, link directions
// and the impedance / drive-strength decode.
// Assumes one 20 MHz clock, synchronous active-low reset, and that pads resolve enables.
//
// Operation
// - Each flag pin has its own direction
// - Flags are inputs, undriven, after reset
// - Low interrupt line raises an interrupt
// - Each interrupt line edge or level selectable
// - Interrupts disabled after reset unless boot strap
// - Timer expiry gives four-cycle high pulse
// - Timer-expired pin sampled as strap in reset
// - Link direction: 0 receive, 1 transmit
// - Link 2 direction pin sampled as strap
// - Impedance code decodes group drive-control enables
// - Drive control 0 max, 1 selected strength
// - Strength select maps code to level directly
// - Priority and emulation outputs always level seven
`timescale 1ns/1ns
module fitpc_top (
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       RST_N_I,
  // Program condition pins
  input  wire logic [3:0] FLAG_DIR_I,
  input  wire logic [3:0] FLAG_OUT_VAL_I,
  input  wire logic [3:0] PROGRAM_CONDITION_PINS_I,
  output logic      [3:0] PROGRAM_CONDITION_PINS_O,
  output logic      [3:0] PROGRAM_CONDITION_PINS_OE_O,
  output logic      [3:0] FLAG_STATE_O,
  // Interrupt requests
  input  wire logic [3:0] INTERRUPT_REQUEST_LINES_N_I,
  input  wire logic [3:0] IRQ_EDGE_MODE_I,
  input  wire logic [3:0] IRQ_ENABLE_SET_I,
  input  wire logic [3:0] IRQ_ACK_I,
  input  wire logic       IRQ_BOOT_STRAP_I,
  output logic      [3:0] IRQ_ENABLED_O,
  output logic      [3:0] IRQ_RAISE_O,
  // Timer expired
  input  wire logic       TIMER0_EXPIRE_I,
  input  wire logic       TIMER0_EXPIRED_PIN_I,
  output logic            TIMER0_EXPIRED_OUT_O,
  output logic            TIMER0_EXPIRED_OE_O,
  output logic            TIMER0_STRAP_O,
  // Link directions
  input  wire logic [3:0] LINK_TRANSMIT_I,
  input  wire logic       PORT2_DIRECTION_PIN_I,
  output logic            PORT0_DIRECTION_OUT_O,
  output logic            PORT1_DIRECTION_OUT_O,
  output logic            PORT2_DIRECTION_OUT_O,
  output logic            PORT2_DIRECTION_OE_O,
  output logic            PORT3_DIRECTION_OUT_O,
  output logic            PORT2_STRAP_O,
  // Impedance and drive strength
  input  wire logic [2:0] IMPEDANCE_SELECT_IN_I,
  input  wire logic [2:0] DRIVE_STRENGTH_SELECT_IN_I,
  output logic            ADC_DIG_CTRL_O,
  output logic            LINK_DIG_CTRL_O,
  output logic            IMP_RESERVED_O,
  output logic      [2:0] ADC_STRENGTH_O,
  output logic      [2:0] LINK_STRENGTH_O,
  output logic      [2:0] CORE_PRIORITY_OUT_STRENGTH_O,
  output logic      [2:0] DATA_PRIORITY_OUT_STRENGTH_O,
  output logic      [2:0] EMULATION_STATUS_OUT_STRENGTH_O
);

  logic [3:0] flag_sync;
  logic [3:0] irq_sync_n;
  logic       tmr_pin_sync;
  logic       l2_pin_sync;

  // Asynchronous pins go through two flops before any logic sees them
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_sync
    fitpc_sync u_flag_sync (
      .clk_i    (CLOCK_I),
      .rst_n_i  (RST_N_I),
      .async_i  (PROGRAM_CONDITION_PINS_I[gi]),
      .rst_val_i(1'b0),
      .sync_o   (flag_sync[gi])
    );
    fitpc_sync u_irq_sync (
      .clk_i    (CLOCK_I),
      .rst_n_i  (RST_N_I),
      .async_i  (INTERRUPT_REQUEST_LINES_N_I[gi]),
      .rst_val_i(1'b1),
      .sync_o   (irq_sync_n[gi])
    );
  end

  fitpc_sync u_tmr_sync (
    .clk_i    (CLOCK_I),
    .rst_n_i  (1'b1),
    .async_i  (TIMER0_EXPIRED_PIN_I),
    .rst_val_i(1'b0),
    .sync_o   (tmr_pin_sync)
  );

  fitpc_sync u_l2_sync (
    .clk_i    (CLOCK_I),
    .rst_n_i  (1'b1),
    .async_i  (PORT2_DIRECTION_PIN_I),
    .rst_val_i(1'b0),
    .sync_o   (l2_pin_sync)
  );

  // Flag direction and output state
  logic [3:0] flag_dir_q;
  logic [3:0] flag_dir_d;
  logic [3:0] flag_out_q;
  logic [3:0] flag_out_d;

  always_comb begin
    flag_dir_d = FLAG_DIR_I;
    flag_out_d = FLAG_OUT_VAL_I;
    if (!RST_N_I) begin
      flag_dir_d = fitpc_pkg::FLAG_DIR_RST;
      flag_out_d = fitpc_pkg::FLAG_OUT_RST;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    flag_dir_q <= flag_dir_d;
    flag_out_q <= flag_out_d;
  end

  assign PROGRAM_CONDITION_PINS_O    = flag_out_q;
  assign PROGRAM_CONDITION_PINS_OE_O = flag_dir_q;
  assign FLAG_STATE_O                = flag_sync;

  // Interrupt enables, edge history and pending flags
  logic [3:0] irq_en_q;
  logic [3:0] irq_en_d;
  logic [3:0] irq_prev_n_q;
  logic [3:0] irq_prev_n_d;
  logic [3:0] irq_pend_q;
  logic [3:0] irq_pend_d;
  logic [3:0] irq_fall;

  always_comb begin
    irq_fall     = irq_prev_n_q & ~irq_sync_n;
    irq_prev_n_d = irq_sync_n;
    irq_en_d     = irq_en_q | IRQ_ENABLE_SET_I;
    // Set beats acknowledge so an edge landing on the clear is kept
    irq_pend_d   = (irq_pend_q & ~IRQ_ACK_I) | (irq_fall & irq_en_q);
    if (!RST_N_I) begin
      irq_prev_n_d = 4'hF;
      irq_pend_d   = fitpc_pkg::IRQ_PEND_RST;
      irq_en_d     = {4{IRQ_BOOT_STRAP_I}};
    end
  end

  always_ff @(posedge CLOCK_I) begin
    irq_en_q     <= irq_en_d;
    irq_prev_n_q <= irq_prev_n_d;
    irq_pend_q   <= irq_pend_d;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (IRQ_EDGE_MODE_I[i] == fitpc_pkg::FITPC_TRIG_EDGE) begin
        IRQ_RAISE_O[i] = irq_pend_q[i];
      end else begin
        IRQ_RAISE_O[i] = irq_en_q[i] & ~irq_sync_n[i];
      end
    end
  end

  assign IRQ_ENABLED_O = irq_en_q;

  // Timer-expired pulse and strap capture
  logic [2:0] tmr_cnt_q;
  logic [2:0] tmr_cnt_d;
  logic       tmr_strap_q;
  logic       tmr_strap_d;
  logic       l2_strap_q;
  logic       l2_strap_d;
  logic       in_rst_q;

  always_comb begin
    tmr_cnt_d   = tmr_cnt_q;
    tmr_strap_d = tmr_strap_q;
    l2_strap_d  = l2_strap_q;
    // A new expiry restarts the full pulse rather than being dropped
    if (TIMER0_EXPIRE_I) begin
      tmr_cnt_d = fitpc_pkg::TMR_PULSE_LEN;
    end else if (tmr_cnt_q != fitpc_pkg::TMR_CNT_RST) begin
      tmr_cnt_d = tmr_cnt_q - 3'h1;
    end
    if (!RST_N_I) begin
      tmr_cnt_d   = fitpc_pkg::TMR_CNT_RST;
      tmr_strap_d = tmr_pin_sync;
      l2_strap_d  = l2_pin_sync;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    tmr_cnt_q   <= tmr_cnt_d;
    tmr_strap_q <= tmr_strap_d;
    l2_strap_q  <= l2_strap_d;
    in_rst_q    <= ~RST_N_I;
  end

  assign TIMER0_EXPIRED_OUT_O = (tmr_cnt_q != fitpc_pkg::TMR_CNT_RST);
  assign TIMER0_EXPIRED_OE_O  = ~in_rst_q & RST_N_I;
  assign TIMER0_STRAP_O       = tmr_strap_q;

  // Link direction outputs
  logic [3:0] link_dir_q;
  logic [3:0] link_dir_d;

  always_comb begin
    link_dir_d = LINK_TRANSMIT_I;
    if (!RST_N_I) begin
      link_dir_d = 4'h0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    link_dir_q <= link_dir_d;
  end

  assign PORT0_DIRECTION_OUT_O = link_dir_q[0];
  assign PORT1_DIRECTION_OUT_O = link_dir_q[1];
  assign PORT2_DIRECTION_OUT_O = link_dir_q[fitpc_pkg::STRAP_LINK_INDEX];
  assign PORT2_DIRECTION_OE_O  = ~in_rst_q & RST_N_I;
  assign PORT3_DIRECTION_OUT_O = link_dir_q[3];
  assign PORT2_STRAP_O         = l2_strap_q;

  // Impedance and drive-strength decode; reserved codes enable neither group
  always_comb begin
    ADC_DIG_CTRL_O  = 1'b0;
    LINK_DIG_CTRL_O = 1'b0;
    IMP_RESERVED_O  = 1'b0;
    unique case (IMPEDANCE_SELECT_IN_I)
      fitpc_pkg::IMP_NONE_A,
      fitpc_pkg::IMP_NONE_B: begin
      end
      fitpc_pkg::IMP_LINK_ONLY: begin
        LINK_DIG_CTRL_O = 1'b1;
      end
      fitpc_pkg::IMP_ADC_ONLY: begin
        ADC_DIG_CTRL_O = 1'b1;
      end
      fitpc_pkg::IMP_BOTH: begin
        ADC_DIG_CTRL_O  = 1'b1;
        LINK_DIG_CTRL_O = 1'b1;
      end
      default: begin
        IMP_RESERVED_O = 1'b1;
      end
    endcase
  end

  assign ADC_STRENGTH_O  = ADC_DIG_CTRL_O ? DRIVE_STRENGTH_SELECT_IN_I
                                          : fitpc_pkg::DS_MAX;
  assign LINK_STRENGTH_O = LINK_DIG_CTRL_O ? DRIVE_STRENGTH_SELECT_IN_I
                                           : fitpc_pkg::DS_MAX;

  assign CORE_PRIORITY_OUT_STRENGTH_O    = fitpc_pkg::DS_MAX;
  assign DATA_PRIORITY_OUT_STRENGTH_O    = fitpc_pkg::DS_MAX;
  assign EMULATION_STATUS_OUT_STRENGTH_O = fitpc_pkg::DS_MAX;

endmodule : fitpc_top

// File: dv/fitpc_checker.sv
// Assertions on the pin control block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module fitpc_checker (
  // Clock and reset
  input wire logic       CLOCK_I,
  input wire logic       RST_N_I,
  // Watched ports
  input wire logic [3:0] FLAG_DIR_I,
  input wire logic [3:0] PROGRAM_CONDITION_PINS_OE_O,
  input wire logic [3:0] INTERRUPT_REQUEST_LINES_N_I,
  input wire logic [3:0] IRQ_EDGE_MODE_I,
  input wire logic [3:0] IRQ_ENABLED_O,
  input wire logic [3:0] IRQ_RAISE_O,
  input wire logic       TIMER0_EXPIRE_I,
  input wire logic       TIMER0_EXPIRED_OUT_O,
  input wire logic [3:0] LINK_TRANSMIT_I,
  input wire logic       PORT0_DIRECTION_OUT_O,
  input wire logic [2:0] IMPEDANCE_SELECT_IN_I,
  input wire logic [2:0] DRIVE_STRENGTH_SELECT_IN_I,
  input wire logic       ADC_DIG_CTRL_O,
  input wire logic       LINK_DIG_CTRL_O,
  input wire logic [2:0] ADC_STRENGTH_O,
  input wire logic [2:0] CORE_PRIORITY_OUT_STRENGTH_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  AST_FLAG_RST: assert property (disable iff (1'b0)
    !RST_N_I |=> PROGRAM_CONDITION_PINS_OE_O == 4'h0) else $error("flag enable in reset");
  AST_FLAG_DIR: assert property (RST_N_I && $past(RST_N_I)
    |=> PROGRAM_CONDITION_PINS_OE_O == $past(FLAG_DIR_I)) else $error("flag enable wrong");
  AST_IRQ_OFF: assert property ((IRQ_RAISE_O & ~IRQ_ENABLED_O) == 4'h0)
    else $error("raise while disabled");
  AST_IRQ_LVL: assert property ((!INTERRUPT_REQUEST_LINES_N_I[2] && !IRQ_EDGE_MODE_I[2]
    && IRQ_ENABLED_O[2])[*4] |-> IRQ_RAISE_O[2]) else $error("level raise missing");
  AST_IRQ_EDGE: assert property ($fell(INTERRUPT_REQUEST_LINES_N_I[0]) && IRQ_EDGE_MODE_I[0]
    && IRQ_ENABLED_O[0] |-> ##[2:4] IRQ_RAISE_O[0]) else $error("edge raise missing");
  AST_TMR_ON: assert property (TIMER0_EXPIRE_I |=> TIMER0_EXPIRED_OUT_O[*4])
    else $error("timer pulse short");
  AST_TMR_ROSE: assert property ($rose(TIMER0_EXPIRED_OUT_O) |-> $past(TIMER0_EXPIRE_I))
    else $error("timer pulse without expiry");
  AST_LINK_DIR: assert property (1'b1 |=> PORT0_DIRECTION_OUT_O == $past(LINK_TRANSMIT_I[0]))
    else $error("link direction wrong");
  AST_IMP: assert property (ADC_DIG_CTRL_O == (IMPEDANCE_SELECT_IN_I == 3'h4
    || IMPEDANCE_SELECT_IN_I == 3'h6) && LINK_DIG_CTRL_O == (IMPEDANCE_SELECT_IN_I == 3'h2
    || IMPEDANCE_SELECT_IN_I == 3'h6)) else $error("impedance decode wrong");
  AST_STRENGTH: assert property (ADC_STRENGTH_O ==
    (ADC_DIG_CTRL_O ? DRIVE_STRENGTH_SELECT_IN_I : 3'h7)) else $error("strength wrong");
  AST_FIXED: assert property (CORE_PRIORITY_OUT_STRENGTH_O == 3'h7)
    else $error("fixed strength wrong");
  cover property (TIMER0_EXPIRE_I ##5 !TIMER0_EXPIRED_OUT_O);
  cover property ($rose(IRQ_RAISE_O[0]));
  cover property (ADC_DIG_CTRL_O && LINK_DIG_CTRL_O);
endmodule : fitpc_checker

bind fitpc_top fitpc_checker i_fitpc_checker (.CLOCK_I, .RST_N_I, .FLAG_DIR_I,
  .PROGRAM_CONDITION_PINS_OE_O, .INTERRUPT_REQUEST_LINES_N_I, .IRQ_EDGE_MODE_I,
  .IRQ_ENABLED_O, .IRQ_RAISE_O, .TIMER0_EXPIRE_I, .TIMER0_EXPIRED_OUT_O, .LINK_TRANSMIT_I,
  .PORT0_DIRECTION_OUT_O, .IMPEDANCE_SELECT_IN_I, .DRIVE_STRENGTH_SELECT_IN_I,
  .ADC_DIG_CTRL_O, .LINK_DIG_CTRL_O, .ADC_STRENGTH_O, .CORE_PRIORITY_OUT_STRENGTH_O);

// File: dv/fitpc_board.sv
// Board model: flag pads with pull-downs, pulled-up interrupt lines, strap pad.
// Assumes the bench never drives a flag that the device drives.
`timescale 1ns/1ns
module fitpc_board (
  // Device side
  input  wire logic [3:0] pin_i,
  input  wire logic [3:0] pin_oe_i,
  input  wire logic       tmr_i,
  input  wire logic       tmr_oe_i,
  // Outside parts
  input  wire logic [3:0] ext_val_i,
  input  wire logic [3:0] ext_en_i,
  input  wire logic [3:0] irq_low_i,
  input  wire logic       strap_i,
  // Pads
  output logic      [3:0] pads_o,
  output logic      [3:0] irq_n_o,
  output logic            tmr_pad_o
);
  assign pads_o    = (pin_oe_i & pin_i) | (ext_en_i & ext_val_i);
  assign irq_n_o   = ~irq_low_i;
  assign tmr_pad_o = tmr_oe_i ? tmr_i : strap_i;
endmodule : fitpc_board

// File: dv/tb_top.sv
// Directed bench for the pin control block.
// Assumes the board model resolves the pads.
`timescale 1ns/1ns
module tb_top;
  logic       clk, rst_n, xp, strap, to, toe, tpad, p0, p1, p2, p3, adc, lnk, rsv, ts, ps;
  logic [3:0] fdir, fval, xv, xe, il, em, es, ack, ltx, pads, po, poe, fst, irqn, ien, rse;
  logic [2:0] imp, ds, as, ls, cs, dps, ems;
  logic [1:0] e;
  logic       p2oe;
  int         n_errors, total_checks;
  fitpc_board i_fitpc_board (.pin_i(po), .pin_oe_i(poe), .tmr_i(to), .tmr_oe_i(toe),
    .ext_val_i(xv), .ext_en_i(xe), .irq_low_i(il), .strap_i(strap), .pads_o(pads),
    .irq_n_o(irqn), .tmr_pad_o(tpad));
  fitpc_top i_fitpc_top (.CLOCK_I(clk), .RST_N_I(rst_n), .FLAG_DIR_I(fdir),
    .FLAG_OUT_VAL_I(fval), .PROGRAM_CONDITION_PINS_I(pads), .PROGRAM_CONDITION_PINS_O(po),
    .PROGRAM_CONDITION_PINS_OE_O(poe), .FLAG_STATE_O(fst), .INTERRUPT_REQUEST_LINES_N_I(irqn),
    .IRQ_EDGE_MODE_I(em), .IRQ_ENABLE_SET_I(es), .IRQ_ACK_I(ack), .IRQ_BOOT_STRAP_I(strap),
    .IRQ_ENABLED_O(ien), .IRQ_RAISE_O(rse), .TIMER0_EXPIRE_I(xp), .TIMER0_EXPIRED_PIN_I(tpad),
    .TIMER0_EXPIRED_OUT_O(to), .TIMER0_EXPIRED_OE_O(toe), .TIMER0_STRAP_O(ts),
    .LINK_TRANSMIT_I(ltx), .PORT2_DIRECTION_PIN_I(strap), .PORT0_DIRECTION_OUT_O(p0),
    .PORT1_DIRECTION_OUT_O(p1), .PORT2_DIRECTION_OUT_O(p2), .PORT2_DIRECTION_OE_O(p2oe),
    .PORT3_DIRECTION_OUT_O(p3), .PORT2_STRAP_O(ps), .IMPEDANCE_SELECT_IN_I(imp),
    .DRIVE_STRENGTH_SELECT_IN_I(ds), .ADC_DIG_CTRL_O(adc), .LINK_DIG_CTRL_O(lnk),
    .IMP_RESERVED_O(rsv), .ADC_STRENGTH_O(as), .LINK_STRENGTH_O(ls),
    .CORE_PRIORITY_OUT_STRENGTH_O(cs), .DATA_PRIORITY_OUT_STRENGTH_O(dps),
    .EMULATION_STATUS_OUT_STRENGTH_O(ems));
  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // Inputs move 5 ns after the edge so sampling never races
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : tick
  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #20000;
    n_errors++;
    results();
  end
  initial begin
    {fdir, fval, xv, xe, il, em, es, ack, ltx} = '0;
    {xp, strap, rst_n} = '0;
    imp = 3'h6;
    ds = 3'h7;
    tick(2);
    rst_n = 1'b1;
    tick(2);
    chk("flag enable", poe, 4'h0);
    il = 4'hf;
    tick(4);
    chk("enabled raise", {ien, rse}, 8'h00);
    il = 4'h0;
    $display("test reset done");
    fdir = 4'ha;
    fval = 4'hf;
    xe = 4'h5;
    xv = 4'h5;
    tick(1);
    chk("flag drive", {poe, po & poe}, 8'haa);
    tick(3);
    chk("flag state", fst, 4'hf);
    $display("test flags done");
    xp = 1'b1;
    tick(1);
    xp = 1'b0;
    for (int i = 0; i < 4; i++) begin
      chk("timer pulse", {to, toe}, 2'h3);
      tick(1);
    end
    chk("timer pulse", to, 1'b0);
    ltx = 4'h5;
    tick(1);
    chk("link dir", {p3, p2, p1, p0}, 4'h5);
    $display("test timer link done");
    ds = 3'h3;
    for (int c = 0; c < 8; c++) begin
      imp = c[2:0];
      #1;
      e = {c == 4 || c == 6, c == 2 || c == 6};
      chk("dig ctrl", {rsv, adc, lnk}, {c == 3 || c == 5 || c == 7, e});
      chk("strength", as, e[1] ? 3'h3 : 3'h7);
    end
    // Both groups enabled so the link strength follows the select input
    imp = 3'h6;
    for (int d = 0; d < 8; d++) begin
      ds = d[2:0];
      #1;
      chk("link strength", ls, d[2:0]);
    end
    chk("fixed strength", {cs, dps, ems}, 9'h1ff);
    $display("test drive done");
    em = 4'h3;
    es = 4'hf;
    tick(1);
    es = 4'h0;
    chk("irq enabled", ien, 4'hf);
    il = 4'hf;
    tick(4);
    chk("raise", rse, 4'hf);
    il = 4'h0;
    ack = 4'h1;
    tick(1);
    ack = 4'h0;
    tick(3);
    chk("raise", rse, 4'h2);
    $display("test irq done");
    strap = 1'b1;
    rst_n = 1'b0;
    tick(4);
    chk("straps", {ts, ps, ien}, 6'h3f);
    chk("reset outs", {poe, to, toe, p3, p2, p1, p0}, 9'h000);
    chk("port2 enable", p2oe, 1'b0);
    strap = 1'b0;
    rst_n = 1'b1;
    tick(1);
    chk("straps held", {ts, ps, ien, toe, p2oe}, 8'hff);
    $display("test strap done");
    results();
  end
endmodule : tb_top
